// [logic/adcrt_consts.vh]
`ifndef ADCRT_CONSTS_VH
`define ADCRT_CONSTS_VH

// ==========================================
// register byte addresses
`define ADCRT_OFS_TRIG 12'h000
`define ADCRT_OFS_RESH 12'h004
`define ADCRT_OFS_RESL 12'h008
`define ADCRT_OFS_CTRL 12'h00C

// ==========================================
// field positions and widths
`define ADCRT_TRIG_W 5
`define ADCRT_RES_W 10
`define ADCRT_CTRL_START 0
`define ADCRT_CTRL_JUSTIFY 1
`define ADCRT_CTRL_ENABLE 2

// ==========================================
// reset values
`define ADCRT_TRIG_RST 5'h00
`define ADCRT_CTRL_RST 3'h0

// ==========================================
// timing
`define ADCRT_CONV_CYCLES 16'h000C

`endif

// [logic/adcrt_edge_detect.v]
`timescale 1ns/10ps
`include "adcrt_consts.vh"

// ==========================================
// rising edge detector on selected trigger
module adcrt_edge_detect (
    input wire mclk,
    input wire rst_b,
    input wire ce,
    input wire level,
    output wire rise
);
    reg prev_reg;

    always @(posedge mclk) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else if (ce) begin
            prev_reg <= level;
        end
    end

    assign rise = ce & level & ~prev_reg;
endmodule

// [logic/adcrt_justify.v]
`timescale 1ns/10ps
`include "adcrt_consts.vh"

// ==========================================
// result packing into high/low pair
module adcrt_justify (
    input wire [9:0] result,
    input wire right_just,
    output wire [7:0] high_byte,
    output wire [7:0] low_byte
);
    assign high_byte = right_just ? {6'h00, result[9:8]}
                                  : result[9:2];
    assign low_byte = right_just ? result[7:0]
                                 : {result[1:0], 6'h00};
endmodule

// [logic/adcrt_top.v]
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "adcrt_consts.vh"

module adcrt_top #(
    parameter NUM_TRIG = 32,
    parameter [15:0] CONV_CYCLES = `ADCRT_CONV_CYCLES
) (
    input wire mclk,
    input wire rst_b,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [NUM_TRIG-1:0] trig_sources,
    input wire [9:0] conv_data,
    output wire conv_busy,
    output wire conv_start,
    output wire conv_done
);
    // ==========================================
    // states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] cnt_reg;
    reg [15:0] cnt_next;
    reg [4:0] trig_sel_reg;
    reg justify_reg;
    reg enable_reg;
    reg [7:0] res_high_reg;
    reg [7:0] res_low_reg;
    wire sel_level;
    wire trig_rise;
    wire [7:0] pack_high;
    wire [7:0] pack_low;
    wire bus_wr;
    wire bus_rd;
    wire addr_ok;
    wire sw_start;
    wire start_req;
    wire en_now;
    wire done_now;

    // ==========================================
    // apb decode, zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == `ADCRT_OFS_TRIG) || (paddr == `ADCRT_OFS_RESH) ||
                     (paddr == `ADCRT_OFS_RESL) || (paddr == `ADCRT_OFS_CTRL);
    assign pslverr = psel & penable & ~addr_ok;
    assign bus_wr = ce & psel & penable & pwrite & addr_ok;
    assign bus_rd = psel & penable & ~pwrite;

    assign sw_start = bus_wr && (paddr == `ADCRT_OFS_CTRL) &&
                      pwdata[`ADCRT_CTRL_START];

    // ==========================================
    // trigger source select and edge
    assign sel_level = trig_sources[trig_sel_reg];

    adcrt_edge_detect u_edge (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .level(sel_level),
        .rise(trig_rise)
    );

    // enable written with the start bit counts at once
    assign en_now = (bus_wr && (paddr == `ADCRT_OFS_CTRL)) ? pwdata[`ADCRT_CTRL_ENABLE] :
                    enable_reg;
    assign start_req = en_now & (sw_start | trig_rise);
    assign done_now = (state_reg == ST_CONV) && (cnt_reg == 16'h0001);

    adcrt_justify u_just (
        .result(conv_data),
        .right_just(justify_reg),
        .high_byte(pack_high),
        .low_byte(pack_low)
    );

    // ==========================================
    // conversion sequencer
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_req) begin
                    state_next = ST_CONV;
                    cnt_next = CONV_CYCLES;
                end
            end
            ST_CONV: begin
                if (!enable_reg) begin
                    state_next = ST_IDLE;
                    cnt_next = 16'h0000;
                end else if (done_now) begin
                    state_next = ST_IDLE;
                    cnt_next = 16'h0000;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = 16'h0000;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign conv_busy = (state_reg == ST_CONV);
    assign conv_start = ce & (state_reg == ST_IDLE) & start_req;
    assign conv_done = ce & done_now & enable_reg;

    // ==========================================
    // control registers
    always @(posedge mclk) begin
        if (!rst_b) begin
            trig_sel_reg <= `ADCRT_TRIG_RST;
            justify_reg <= 1'b0;
            enable_reg <= 1'b0;
        end else if (bus_wr) begin
            if (paddr == `ADCRT_OFS_TRIG) begin
                trig_sel_reg <= pwdata[4:0];
            end
            if (paddr == `ADCRT_OFS_CTRL) begin
                justify_reg <= pwdata[`ADCRT_CTRL_JUSTIFY];
                enable_reg <= pwdata[`ADCRT_CTRL_ENABLE];
            end
        end
    end

    // ==========================================
    // result registers, untouched by reset
    always @(posedge mclk) begin
        if (ce) begin
            if (done_now && enable_reg) begin
                res_high_reg <= pack_high;
                res_low_reg <= pack_low;
            end else if (bus_wr && (paddr == `ADCRT_OFS_RESH)) begin
                res_high_reg <= pwdata[7:0];
            end else if (bus_wr && (paddr == `ADCRT_OFS_RESL)) begin
                res_low_reg <= pwdata[7:0];
            end
        end
    end

    // ==========================================
    // read mux
    always @* begin
        prdata = 32'h00000000;
        if (bus_rd) begin
            case (paddr)
                `ADCRT_OFS_TRIG: prdata = {27'h0000000, trig_sel_reg};
                `ADCRT_OFS_RESH: prdata = {24'h000000, res_high_reg};
                `ADCRT_OFS_RESL: prdata = {24'h000000, res_low_reg};
                `ADCRT_OFS_CTRL: prdata = {29'h00000000, enable_reg, justify_reg,
                                           conv_busy};
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule

// [test/adcrt_chk.sv]
`timescale 1ns/10ps
// ==========================================
// port checker
module adcrt_chk #(
    parameter NUM_TRIG = 32,
    parameter [15:0] CONV_CYCLES = 16'h000C
) (
    input logic mclk,
    input logic rst_b,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pslverr,
    input logic [NUM_TRIG-1:0] trig_sources,
    input logic conv_busy,
    input logic conv_start,
    input logic conv_done
);
    logic [15:0] cnt_reg;
    wire rd_acc = psel && penable && !pwrite;
    wire ctl_wr = psel && penable && pwrite && paddr == 12'h00C;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always @(posedge mclk) cnt_reg <= (rst_b && conv_busy) ? cnt_reg + 16'h0001 : 16'h0000;
    start_busy_a: assert property (conv_start |=> conv_busy) else $error("no busy");
    done_len_a: assert property (conv_done |-> cnt_reg == CONV_CYCLES - 16'h0001)
        else $error("bad length");
    done_clr_a: assert property (conv_done |=> !conv_busy) else $error("busy kept");
    done_busy_a: assert property (conv_done |-> conv_busy) else $error("idle done");
    busy_nostart_a: assert property (conv_busy |-> !conv_start) else $error("restart");
    trig_edge_a: assert property (conv_start && !ctl_wr && $past(rst_b)
        |-> |(trig_sources & ~$past(trig_sources))) else $error("start without edge");
    trig_hi_a: assert property (rd_acc && paddr == 12'h000 |-> prdata[31:5] == 27'h0)
        else $error("trig upper bits");
    bus_err_a: assert property (psel && penable && paddr > 12'h00C |-> pslverr && prdata == 0)
        else $error("unmapped");
    cover property (conv_done);
    cover property (conv_start && !ctl_wr);
    cover property (pslverr);
endmodule
bind adcrt_top adcrt_chk #(.NUM_TRIG(NUM_TRIG), .CONV_CYCLES(CONV_CYCLES)) i_adcrt_chk (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .trig_sources(trig_sources),
    .conv_busy(conv_busy), .conv_start(conv_start), .conv_done(conv_done));

// [test/adcrt_tb.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
// ==========================================
// bench
module testbench;
    reg mclk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, serr;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rdat, trig = 32'h0;
    reg [9:0] cdata = 10'h000;
    wire [31:0] prdata;
    wire pready, pslverr, conv_busy, conv_start, conv_done;
    integer n_mismatch = 0, check_count = 0;
    always #25 mclk = ~mclk;
    adcrt_top i_adcrt_top (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_sources(trig), .conv_data(cdata),
        .conv_busy(conv_busy), .conv_start(conv_start), .conv_done(conv_done));
    task end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task xfer(input [11:0] a, input w, input [31:0] d);
        integer k;
        @(posedge mclk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        k = 0;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin n_mismatch++; end_of_test; end
        rdat = prdata; serr = pslverr; psel <= 0; penable <= 0;
    endtask
    task rd(input [11:0] a, input [31:0] e);
        xfer(a, 0, 0); `CHK(rdat, e)
    endtask
    task wdone;
        integer k;
        k = 0;
        while (conv_done !== 1'b1 && k < 60) begin @(posedge mclk); k++; end
        if (k >= 60) begin n_mismatch++; end_of_test; end
    endtask
    task conv(input [31:0] c, input [9:0] v, input [7:0] h, input [7:0] l);
        cdata <= v; xfer(12'h00C, 1, c); xfer(12'h00C, 0, 0);
        `CHK(rdat[0], 1'b1)
        wdone; rd(12'h004, {24'h0, h}); rd(12'h008, {24'h0, l});
    endtask
    task rst5;
        rst_b <= 0; repeat (5) @(posedge mclk); rst_b <= 1;
    endtask
    initial begin
        rst5;
        rd(12'h000, 0);
        xfer(12'h000, 1, 32'hFF); rd(12'h000, 32'h1F);
        rd(12'h010, 0); `CHK(serr, 1'b1)
        $display("register test done");
        conv(5, 10'h2A5, 8'hA9, 8'h40);
        conv(7, 10'h2A5, 8'h02, 8'hA5);
        $display("software start test done");
        xfer(12'h000, 1, 3); xfer(12'h00C, 1, 6); cdata <= 10'h155;
        @(posedge mclk) trig[4] <= 1;
        repeat (20) @(posedge mclk);
        `CHK(conv_busy, 1'b0)
        trig[3] <= 1; wdone; repeat (20) @(posedge mclk);
        `CHK(conv_busy, 1'b0)
        rd(12'h004, 32'h01); rd(12'h008, 32'h55);
        $display("trigger test done");
        rst5;
        rd(12'h000, 0); rd(12'h008, 32'h55);
        ce <= 0; xfer(12'h000, 1, 32'h5); ce <= 1; rd(12'h000, 0);
        $display("reset test done");
        end_of_test;
    end
endmodule
